// ### bstap_dev.sv
// device end: tap controller, instruction decode, bypass and boundary scan
//
// Overview of operation
// [R1] tms sampled on tck rise steers controller
// [R2] tdi sampled on tck rising edge
// [R3] tdo driven only in shift states, falling
// [R4] three-bit instruction register, no parity
// [R5] active instruction changes only in update-ir or test-logic-reset
// [R6] test-logic-reset loads all-ones bypass instruction
// [R7] capture-ir loads fixed value 001
// [R8] instruction bits enter lsb first
// [R9] decode six instruction codes to registers
// [R10] external test selects chain, resets core
// [R11] highz resets core, bypass, floats pins
// [R12] five tms-high edges reach test-logic-reset
// [R13] sample captures pins in capture-dr, transparently
// [R14] preload latches chain in update-dr
// [R15] clamp drives pins from chain, bypass path
// [R16] bypass captures zero in capture-dr
// [R17] tester synchronises its sampling to bus clock
// [R18] unassigned and private codes select bypass
// [R19] chain is 188 cells, bit zero first
// [R20] control cells cleared in test-logic-reset
// [R21] power-on detect holds test-logic-reset
// [R22] core reset starts tenth clock after exit
`timescale 1ns/100ps
`include "bstap_regs.svh"

module bstap_dev
  import bstap_pkg::*;
#(
  parameter int                  BSR_LEN  = `BSTAP_BSR_LEN,
  parameter logic [BSR_LEN-1:0]  CTL_MASK = '0
)
(
  // system
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               por,
  // test access link
  bstap_if.dev                    jtag,
  // system pins seen by the chain and by the exit window
  input  wire logic [BSR_LEN-1:0] pins_in,
  input  wire logic               processor_reset_input_n,
  // controls toward the core and pad ring
  output logic [BSR_LEN-1:0]      bsr_out,
  output logic                    pins_from_bsr,
  output logic                    pins_highz,
  output logic                    core_reset,
  output logic                    reset_start,
  output logic [2:0]              active_instr
);
  // instruction that routes the chain, else the bypass bit is used
  function automatic logic sel_chain(input logic [2:0] ir);
    sel_chain = (ir == ins_extest) || (ir == ins_sample); // [R9] [R18]
  endfunction
  // controller transition on one tck rise
  function automatic bstap_state_t tap_next(input bstap_state_t s, input logic m);
    case (s)
      st_reset:    tap_next = m ? st_reset    : st_idle;
      st_idle:     tap_next = m ? st_sel_dr   : st_idle;
      st_sel_dr:   tap_next = m ? st_sel_ir   : st_cap_dr;
      st_cap_dr:   tap_next = m ? st_exit1_dr : st_shift_dr;
      st_shift_dr: tap_next = m ? st_exit1_dr : st_shift_dr;
      st_exit1_dr: tap_next = m ? st_upd_dr   : st_pause_dr;
      st_pause_dr: tap_next = m ? st_exit2_dr : st_pause_dr;
      st_exit2_dr: tap_next = m ? st_upd_dr   : st_shift_dr;
      st_upd_dr:   tap_next = m ? st_sel_dr   : st_idle;
      st_sel_ir:   tap_next = m ? st_reset    : st_cap_ir;
      st_cap_ir:   tap_next = m ? st_exit1_ir : st_shift_ir;
      st_shift_ir: tap_next = m ? st_exit1_ir : st_shift_ir;
      st_exit1_ir: tap_next = m ? st_upd_ir   : st_pause_ir;
      st_pause_ir: tap_next = m ? st_exit2_ir : st_pause_ir;
      st_exit2_ir: tap_next = m ? st_upd_ir   : st_shift_ir;
      st_upd_ir:   tap_next = m ? st_sel_dr   : st_idle;
      default:     tap_next = st_reset;
    endcase
  endfunction
  // pin synchronisers; stage one feeds stage two only
  logic tck_s1_reg, tck_s2_reg, tck_s3_reg;
  logic tms_s1_reg, tms_s2_reg;
  logic tdi_s1_reg, tdi_s2_reg;
  logic prst_s1_reg, prst_s2_reg;
  logic tck_rise, tck_fall;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tck_s1_reg  <= 1'b0;
      tck_s2_reg  <= 1'b0;
      tck_s3_reg  <= 1'b0;
      tms_s1_reg  <= 1'b1;
      tms_s2_reg  <= 1'b1;
      tdi_s1_reg  <= 1'b1;
      tdi_s2_reg  <= 1'b1;
      prst_s1_reg <= 1'b1;
      prst_s2_reg <= 1'b1;
    end
    else
    begin
      tck_s1_reg  <= jtag.tck;
      tck_s2_reg  <= tck_s1_reg;
      tck_s3_reg  <= tck_s2_reg;
      tms_s1_reg  <= jtag.tms;
      tms_s2_reg  <= tms_s1_reg;
      tdi_s1_reg  <= jtag.tdi;
      tdi_s2_reg  <= tdi_s1_reg;
      prst_s1_reg <= processor_reset_input_n;
      prst_s2_reg <= prst_s1_reg;
    end
  end
  // tms and tdi pass the same depth as tck, so they stay aligned to its edges
  assign tck_rise = tck_s2_reg & ~tck_s3_reg;
  assign tck_fall = ~tck_s2_reg & tck_s3_reg;
  // controller and scan state
  bstap_state_t       state_reg, state_next;
  logic [2:0]         ir_shift_reg, ir_shift_next;
  logic [2:0]         ir_reg, ir_next;
  logic               byp_reg, byp_next;
  logic [BSR_LEN-1:0] bsr_shift_reg, bsr_shift_next;
  logic [BSR_LEN-1:0] bsr_upd_reg, bsr_upd_next;
  logic               tdo_reg, tdo_next;
  logic               tdo_oe_reg, tdo_oe_next;
  always_comb
  begin
    state_next     = state_reg;
    ir_shift_next  = ir_shift_reg;
    ir_next        = ir_reg;
    byp_next       = byp_reg;
    bsr_shift_next = bsr_shift_reg;
    bsr_upd_next   = bsr_upd_reg;
    tdo_next       = tdo_reg;
    tdo_oe_next    = tdo_oe_reg;
    // rising edge: advance, capture and shift
    if (tck_rise)
    begin
      state_next = tap_next(state_reg, tms_s2_reg); // [R1] [R12]
      case (state_reg)
        st_cap_ir:
          ir_shift_next = `BSTAP_IR_CAPTURE; // [R7]
        st_shift_ir:
          ir_shift_next = {tdi_s2_reg, ir_shift_reg[2:1]}; // [R2] [R4] [R8]
        st_cap_dr:
        begin
          if (sel_chain(ir_reg))
            bsr_shift_next = pins_in; // [R13]
          else
            byp_next = 1'b0; // [R16]
        end
        st_shift_dr:
        begin
          if (sel_chain(ir_reg))
            bsr_shift_next = {tdi_s2_reg, bsr_shift_reg[BSR_LEN-1:1]}; // [R19]
          else
            byp_next = tdi_s2_reg; // [R2]
        end
        default: ;
      endcase
    end
    // falling edge: update stages and tdo
    if (tck_fall)
    begin
      if (state_reg == st_upd_ir)
        ir_next = ir_shift_reg; // [R5]
      if (state_reg == st_upd_dr && sel_chain(ir_reg))
        bsr_upd_next = bsr_shift_reg; // [R14]
      tdo_oe_next = (state_reg == st_shift_ir) || (state_reg == st_shift_dr); // [R3]
      if (state_reg == st_shift_ir)
        tdo_next = ir_shift_reg[0]; // [R3]
      else if (state_reg == st_shift_dr)
        tdo_next = sel_chain(ir_reg) ? bsr_shift_reg[0] : byp_reg; // [R19]
    end
    // power-on detect overrides anything the tester sends
    if (por)
      state_next = st_reset; // [R21]
    // test-logic-reset forces bypass and safe control cells
    if (state_reg == st_reset)
    begin
      ir_next      = `BSTAP_IR_RESET; // [R6]
      bsr_upd_next = bsr_upd_reg & ~CTL_MASK; // [R20]
      tdo_oe_next  = 1'b0;
    end
  end
  // register controller and scan state
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg     <= st_reset;
      ir_shift_reg  <= `BSTAP_IR_RESET;
      ir_reg        <= `BSTAP_IR_RESET;
      byp_reg       <= 1'b0;
      bsr_shift_reg <= '0;
      bsr_upd_reg   <= '0;
      tdo_reg       <= 1'b1;
      tdo_oe_reg    <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      ir_shift_reg  <= ir_shift_next;
      ir_reg        <= ir_next;
      byp_reg       <= byp_next;
      bsr_shift_reg <= bsr_shift_next;
      bsr_upd_reg   <= bsr_upd_next;
      tdo_reg       <= tdo_next;
      tdo_oe_reg    <= tdo_oe_next;
    end
  end
  // instruction side effects and the exit window after external test
  logic       from_bsr_reg, from_bsr_next;
  logic       highz_reg, highz_next;
  logic       core_rst_reg, core_rst_next;
  logic       start_reg, start_next;
  logic [3:0] exit_cnt_reg, exit_cnt_next;
  logic       was_extest;
  assign was_extest = (ir_reg == ins_extest);
  always_comb
  begin
    from_bsr_next = (ir_reg == ins_extest) || (ir_reg == ins_clamp); // [R10] [R15]
    highz_next    = (ir_reg == ins_highz); // [R11]
    core_rst_next = (ir_reg == ins_extest) || (ir_reg == ins_highz); // [R10] [R11]
    exit_cnt_next = exit_cnt_reg;
    start_next    = 1'b0;
    // counting is armed on the clock the core reset lifts after external test
    if (core_rst_reg && !core_rst_next && from_bsr_reg && !was_extest)
      exit_cnt_next = 4'h1;
    else if (exit_cnt_reg != 4'h0)
    begin
      if (!prst_s2_reg)
        exit_cnt_next = 4'h0; // [R22]
      else if (exit_cnt_reg == 4'(`BSTAP_EXIT_START))
      begin
        exit_cnt_next = 4'h0;
        start_next    = 1'b1; // [R22]
      end
      else
        exit_cnt_next = exit_cnt_reg + 4'h1;
    end
  end
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      from_bsr_reg <= 1'b0;
      highz_reg    <= 1'b0;
      core_rst_reg <= 1'b0;
      start_reg    <= 1'b0;
      exit_cnt_reg <= 4'h0;
    end
    else
    begin
      from_bsr_reg <= from_bsr_next;
      highz_reg    <= highz_next;
      core_rst_reg <= core_rst_next;
      start_reg    <= start_next;
      exit_cnt_reg <= exit_cnt_next;
    end
  end
  // outputs straight from flip-flops
  assign jtag.tdo      = tdo_reg;
  assign jtag.tdo_oe   = tdo_oe_reg;
  assign bsr_out       = bsr_upd_reg;
  assign pins_from_bsr = from_bsr_reg;
  assign pins_highz    = highz_reg;
  assign core_reset    = core_rst_reg;
  assign reset_start   = start_reg;
  assign active_instr  = ir_reg;
endmodule

// ### bstap_host.sv
// tester end: makes tck, walks the controller and scans ir or dr
`timescale 1ns/100ps
`include "bstap_regs.svh"

module bstap_host
  import bstap_pkg::*;
#(
  parameter int MAXLEN = `BSTAP_BSR_LEN,
  parameter int HALF   = `BSTAP_TCK_HALF_CYC,
  parameter int LW     = 8
)
(
  // system
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // test access link
  bstap_if.host                  jtag,
  // user command
  input  wire logic              start,
  input  wire logic [1:0]        op,
  input  wire logic [LW-1:0]     len,
  input  wire logic [MAXLEN-1:0] wdata,
  // user answer
  output logic                   busy,
  output logic                   done,
  output logic [MAXLEN-1:0]      rdata
);

  // tdo comes from the other party: two flip-flops first
  logic tdo_s1_reg, tdo_s2_reg;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tdo_s1_reg <= 1'b1;
      tdo_s2_reg <= 1'b1;
    end
    else
    begin
      tdo_s1_reg <= jtag.tdo_line;
      tdo_s2_reg <= tdo_s1_reg;
    end
  end

  bstap_hstate_t     st_reg, st_next;
  logic [7:0]        cnt_reg, cnt_next;
  logic              tck_reg, tck_next;
  logic              tms_reg, tms_next;
  logic              tdi_reg, tdi_next;
  logic [LW-1:0]     bit_reg, bit_next;
  logic [5:0]        pat_reg, pat_next;
  logic [2:0]        plen_reg, plen_next;
  logic [1:0]        op_reg, op_next;
  logic [LW-1:0]     len_reg, len_next;
  logic [MAXLEN-1:0] wd_reg, wd_next;
  logic [MAXLEN-1:0] rd_reg, rd_next;
  logic              done_reg, done_next;
  logic              busy_reg, busy_next;
  logic              bit_end;

  // a tck period is HALF low then HALF high; tdo is read late in the high half
  assign bit_end = (cnt_reg == 8'(2 * HALF - 1));

  always_comb
  begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    tck_next  = tck_reg;
    tms_next  = tms_reg;
    tdi_next  = tdi_reg;
    bit_next  = bit_reg;
    pat_next  = pat_reg;
    plen_next = plen_reg;
    op_next   = op_reg;
    len_next  = len_reg;
    wd_next   = wd_reg;
    rd_next   = rd_reg;
    done_next = 1'b0;
    if (st_reg != h_idle)
    begin
      cnt_next = bit_end ? 8'h00 : cnt_reg + 8'h01;
      if (cnt_reg == 8'(HALF - 1))
        tck_next = 1'b1; // [R1] [R2]
      if (bit_end)
        tck_next = 1'b0;
    end
    case (st_reg)
      h_idle:
      begin
        tms_next = 1'b0;
        if (start)
        begin
          op_next  = op;
          len_next = len;
          wd_next  = wdata;
          cnt_next = 8'h00;
          bit_next = '0;
          st_next  = h_pre;
          if (op == op_reset)
          begin
            pat_next  = `BSTAP_PAT_RESET; // [R12]
            plen_next = 3'(`BSTAP_LEN_RESET);
          end
          else if (op == op_ir)
          begin
            pat_next  = `BSTAP_PAT_IR;
            plen_next = 3'(`BSTAP_LEN_IR);
          end
          else
          begin
            pat_next  = `BSTAP_PAT_DR;
            plen_next = 3'(`BSTAP_LEN_DR);
          end
          tms_next = pat_next[0];
        end
      end
      h_pre:
        if (bit_end)
        begin
          if (bit_reg == LW'(plen_reg - 3'h1))
          begin
            bit_next = '0;
            if (op_reg == op_reset)
            begin
              st_next   = h_idle;
              done_next = 1'b1;
            end
            else
            begin
              st_next  = h_data;
              tms_next = (len_reg == LW'(1));
              tdi_next = wd_reg[0]; // [R8]
            end
          end
          else
          begin
            bit_next = bit_reg + LW'(1);
            tms_next = pat_reg[bit_next[2:0]];
          end
        end
      h_data:
        if (bit_end)
        begin
          rd_next[bit_reg] = tdo_s2_reg; // [R19]
          if (bit_reg == len_reg - LW'(1))
          begin
            st_next  = h_post;
            bit_next = '0;
            tms_next = 1'b1;
          end
          else
          begin
            bit_next = bit_reg + LW'(1);
            tms_next = (bit_next == len_reg - LW'(1));
            tdi_next = wd_reg[bit_next]; // [R8] [R19]
          end
        end
      h_post:
        if (bit_end)
        begin
          if (bit_reg == '0)
          begin
            bit_next = LW'(1);
            tms_next = 1'b0;
          end
          else
          begin
            st_next   = h_idle;
            done_next = 1'b1;
          end
        end
      default:
        st_next = h_idle;
    endcase
    // busy follows the next state so the output leaves a flip-flop
    busy_next = (st_next != h_idle);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_reg   <= h_idle;
      cnt_reg  <= 8'h00;
      tck_reg  <= 1'b0;
      tms_reg  <= 1'b1;
      tdi_reg  <= 1'b1;
      bit_reg  <= '0;
      pat_reg  <= 6'h00;
      plen_reg <= 3'h0;
      op_reg   <= 2'h0;
      len_reg  <= '0;
      wd_reg   <= '0;
      rd_reg   <= '0;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
    end
    else
    begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      tck_reg  <= tck_next;
      tms_reg  <= tms_next;
      tdi_reg  <= tdi_next;
      bit_reg  <= bit_next;
      pat_reg  <= pat_next;
      plen_reg <= plen_next;
      op_reg   <= op_next;
      len_reg  <= len_next;
      wd_reg   <= wd_next;
      rd_reg   <= rd_next;
      done_reg <= done_next;
      busy_reg <= busy_next;
    end
  end

  // outputs straight from flip-flops
  assign jtag.tck = tck_reg;
  assign jtag.tms = tms_reg;
  assign jtag.tdi = tdi_reg;
  assign busy     = busy_reg;
  assign done     = done_reg;
  assign rdata    = rd_reg;

endmodule

// ### bstap_if.sv
// four-wire test access link between the tester and the device
`timescale 1ns/100ps
interface bstap_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;
  logic tdo_line;

  // tdo floats when not driven; the tester sees the pull level then
  assign tdo_line = tdo_oe ? tdo : 1'b1;

  modport dev  (input tck, input tms, input tdi, output tdo, output tdo_oe);
  modport host (output tck, output tms, output tdi, input tdo_line);
endinterface

// ### bstap_link_sva.sv
// concurrent checks on the test access link between tester and device
`timescale 1ns/100ps
module bstap_link_sva
  import bstap_pkg::*;
(
  // system
  input logic clk,
  input logic sys_rst,
  // test link
  input logic tck,
  input logic tms,
  input logic tdi,
  input logic tdo,
  input logic tdo_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic         tck_reg;
  bstap_state_t st_reg;
  bstap_state_t st_next;
  logic [2:0]   ones_reg;
  logic [2:0]   ones_next;
  logic         in_shift;

  // shadow controller stepped on the raw tck rise, so it leads the device by the sync delay
  always_comb
  begin
    st_next   = st_reg;
    ones_next = ones_reg;
    if (tck && !tck_reg)
    begin
      ones_next = !tms ? 3'h0 : ((ones_reg == 3'h5) ? ones_reg : ones_reg + 3'h1);
      case (st_reg)
        st_reset:    st_next = tms ? st_reset : st_idle;
        st_idle:     st_next = tms ? st_sel_dr : st_idle;
        st_sel_dr:   st_next = tms ? st_sel_ir : st_cap_dr;
        st_cap_dr:   st_next = tms ? st_exit1_dr : st_shift_dr;
        st_shift_dr: st_next = tms ? st_exit1_dr : st_shift_dr;
        st_exit1_dr: st_next = tms ? st_upd_dr : st_pause_dr;
        st_pause_dr: st_next = tms ? st_exit2_dr : st_pause_dr;
        st_exit2_dr: st_next = tms ? st_upd_dr : st_shift_dr;
        st_upd_dr:   st_next = tms ? st_sel_dr : st_idle;
        st_sel_ir:   st_next = tms ? st_reset : st_cap_ir;
        st_cap_ir:   st_next = tms ? st_exit1_ir : st_shift_ir;
        st_shift_ir: st_next = tms ? st_exit1_ir : st_shift_ir;
        st_exit1_ir: st_next = tms ? st_upd_ir : st_pause_ir;
        st_pause_ir: st_next = tms ? st_exit2_ir : st_pause_ir;
        st_exit2_ir: st_next = tms ? st_upd_ir : st_shift_ir;
        st_upd_ir:   st_next = tms ? st_sel_dr : st_idle;
        default:     st_next = st_reset;
      endcase
    end
  end

  // register the shadow state
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tck_reg  <= 1'b0;
      st_reg   <= st_reset;
      ones_reg <= 3'h0;
    end
    else
    begin
      tck_reg  <= tck;
      st_reg   <= st_next;
      ones_reg <= ones_next;
    end
  end

  assign in_shift = (st_reg == st_shift_ir) || (st_reg == st_shift_dr);

  AST_TCK_HIGH: assert property ($rose(tck) |-> tck [*4] ##1 !tck)
    else $error("tck high phase is not four clocks");
  AST_TCK_LOW: assert property ($fell(tck) |-> !tck [*3])
    else $error("tck low phase too short for the device");
  AST_TMS_EDGE: assert property ($changed(tms) |-> !tck)
    else $error("tms moved while tck high");
  AST_TDI_EDGE: assert property ($changed(tdi) |-> !tck)
    else $error("tdi moved while tck high");
  AST_TDO_FALL: assert property (($changed(tdo) || $changed(tdo_oe))
    |-> (!$past(tck, 3) || !$past(tck, 4) || !$past(tck, 5)))
    else $error("tdo changed without a preceding tck fall");
  AST_OE_ON: assert property ($rose(tdo_oe) |-> $past(in_shift, 2))
    else $error("tdo driven outside a shift state");
  AST_OE_OFF: assert property ($fell(tdo_oe) |-> !$past(in_shift, 2))
    else $error("tdo released while still shifting");
  AST_TLR_FIVE: assert property ((ones_reg == 3'h5) |-> !tdo_oe)
    else $error("tdo still driven after five tms-high rises");

  // main scenarios reached
  cover property (ones_reg == 3'h5);
  cover property ($rose(tdo_oe));
  cover property (st_reg == st_shift_dr && tck && !tck_reg);
endmodule

// ### bstap_pkg.sv
// types shared by both ends of the boundary-scan test access link
package bstap_pkg;

  // sixteen controller states, one-hot
  typedef enum logic [15:0] {
    st_reset    = 16'h0001,
    st_idle     = 16'h0002,
    st_sel_dr   = 16'h0004,
    st_cap_dr   = 16'h0008,
    st_shift_dr = 16'h0010,
    st_exit1_dr = 16'h0020,
    st_pause_dr = 16'h0040,
    st_exit2_dr = 16'h0080,
    st_upd_dr   = 16'h0100,
    st_sel_ir   = 16'h0200,
    st_cap_ir   = 16'h0400,
    st_shift_ir = 16'h0800,
    st_exit1_ir = 16'h1000,
    st_pause_ir = 16'h2000,
    st_exit2_ir = 16'h4000,
    st_upd_ir   = 16'h8000
  } bstap_state_t;

  // instruction codes
  typedef enum logic [2:0] {
    ins_extest  = 3'h0,
    ins_highz   = 3'h1,
    ins_sample  = 3'h2,
    ins_clamp   = 3'h4,
    ins_private = 3'h6,
    ins_bypass  = 3'h7
  } bstap_instr_t;

  // host operations
  typedef enum logic [1:0] {
    op_reset = 2'h0,
    op_ir    = 2'h1,
    op_dr    = 2'h2
  } bstap_op_t;

  // host sequencer states
  typedef enum logic [3:0] {
    h_idle = 4'h1,
    h_pre  = 4'h2,
    h_data = 4'h4,
    h_post = 4'h8
  } bstap_hstate_t;

endpackage

// ### bstap_regs.svh
// constants shared by both ends of the boundary-scan test access link
`ifndef BSTAP_REGS_SVH
`define BSTAP_REGS_SVH

// instruction register
`define BSTAP_IR_W          3
`define BSTAP_IR_RESET      3'h7
`define BSTAP_IR_CAPTURE    3'h1

// boundary scan chain
`define BSTAP_BSR_LEN       188

// tms high edges that force test-logic-reset from any state
`define BSTAP_TLR_ONES      5

// processor reset window after leaving external test, in bus clocks
`define BSTAP_EXIT_WINDOW   8
`define BSTAP_EXIT_START    10

// host tms patterns, lsb sent first, and their lengths
`define BSTAP_PAT_RESET     6'h1f
`define BSTAP_LEN_RESET     6
`define BSTAP_PAT_DR        6'h01
`define BSTAP_LEN_DR        3
`define BSTAP_PAT_IR        6'h03
`define BSTAP_LEN_IR        4

// host test clock timing
`define BSTAP_CLK_MHZ       100
`define BSTAP_TCK_HALF_NS   40
`define BSTAP_TCK_HALF_CYC  ((`BSTAP_TCK_HALF_NS * `BSTAP_CLK_MHZ + 999) / 1000)

`endif

// ### testbench.sv
// self-checking bench joining tester and device ends over the test link
`timescale 1ns/100ps
`include "bstap_regs.svh"
module testbench
  import bstap_pkg::*;
;
  localparam int           L   = `BSTAP_BSR_LEN;
  localparam logic [L-1:0] CTL = 188'h30000000000000011;

  logic             clk, sys_rst, por, start, rsi_n, busy, done;
  logic             pins_from_bsr, pins_highz, core_reset, reset_start;
  logic [1:0]       op;
  logic [7:0]       len;
  logic [2:0]       active_instr;
  logic [L-1:0]     wdata, rdata, pins_in, bsr_out, w, v, ee, em;
  logic [L-1:0]     exp_q[$], msk_q[$];
  int               err_total = 0, n_checks = 0, rs_cnt = 0, rs0;

  bstap_if link ();

  bstap_dev #(.CTL_MASK(CTL)) bstap_dev_inst (
    .clk(clk), .sys_rst(sys_rst), .por(por), .jtag(link), .pins_in(pins_in),
    .processor_reset_input_n(rsi_n), .bsr_out(bsr_out), .pins_from_bsr(pins_from_bsr),
    .pins_highz(pins_highz), .core_reset(core_reset), .reset_start(reset_start),
    .active_instr(active_instr));

  bstap_host bstap_host_inst (
    .clk(clk), .sys_rst(sys_rst), .jtag(link), .start(start), .op(op), .len(len),
    .wdata(wdata), .busy(busy), .done(done), .rdata(rdata));

  bstap_link_sva bstap_link_sva_inst (
    .clk(clk), .sys_rst(sys_rst), .tck(link.tck), .tms(link.tms), .tdi(link.tdi),
    .tdo(link.tdo), .tdo_oe(link.tdo_oe));

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [L-1:0] got, input logic [L-1:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  function automatic logic [L-1:0] rnd();
    logic [L-1:0] r;
    r = '0;
    for (int i = 0; i < 6; i++)
      r = {r[L-33:0], $urandom()};
    return r;
  endfunction

  // one host command; the expected scan data is queued before the request goes out
  task automatic run(input logic [1:0] o, input int n, input logic [L-1:0] d,
                     input logic [L-1:0] e, input logic [L-1:0] m);
    logic [2:0] prev;
    int         k;
    prev = active_instr;
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge clk);
    start <= 1'b1;
    op <= o;
    len <= n[7:0];
    wdata <= d;
    @(posedge clk);
    start <= 1'b0;
    repeat (40) @(posedge clk);
    chk(busy, 1'b1, "host busy mid scan");
    if (o != op_reset)
      chk(active_instr, prev, "instruction moved during shift");
    for (k = 0; k < 4000 && done !== 1'b1; k++)
      @(negedge clk);
    if (k == 4000)
      chk(1'b0, 1'b1, "host never finished");
    repeat (4) @(posedge clk);
    chk(busy, 1'b0, "host idle after done");
  endtask

  // mode outputs expected for each code; unassigned and private codes touch no pins
  task automatic mode(input logic [2:0] c);
    logic [2:0] e;
    e = {c == 3'h0 || c == 3'h4, c == 3'h1, c == 3'h0 || c == 3'h1};
    chk(active_instr, c, "active instruction");
    chk({pins_from_bsr, pins_highz, core_reset}, e, "mode outputs");
  endtask

  // scoreboard: oldest note against each finished scan
  always @(negedge clk)
    if (done === 1'b1)
    begin
      ee = exp_q.pop_front();
      em = msk_q.pop_front();
      chk(rdata & em, ee, "scan data");
    end

  always @(posedge clk)
    if (reset_start === 1'b1)
      rs_cnt++;

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // longest path is well under 30000 clocks
  initial
  begin
    #600000;
    err_total++;
    $display("wrong value at %0t: watchdog expired", $time);
    final_report();
  end

  initial
  begin
    sys_rst = 1'b1;
    {por, start, op, len, wdata, pins_in} = '0;
    rsi_n = 1'b1;
    void'($urandom(32'h3d6aa77e));
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    pins_in <= rnd(); // pins stand still, so capture needs no sync
    run(op_reset, 1, '0, '0, '0);
    chk(active_instr, 3'h7, "instruction after reset");
    // every code: capture value out lsb first, decode, then an 8-bit data scan
    for (int c = 0; c < 8; c++)
    begin
      run(op_ir, 3, c, 3'h1, 3'h7);
      mode(c[2:0]);
      w = rnd();
      run(op_dr, 8, w, {w[6:0], 1'b0}, (c == 0 || c == 2) ? '0 : 8'hff);
    end
    // sample pins through the whole chain, preload the update stage
    w = rnd() | CTL;
    run(op_ir, 3, 3'h2, 3'h1, 3'h7);
    run(op_dr, L, w, pins_in, '1);
    chk(bsr_out, w, "preload latched");
    // clamp holds the preloaded pins while the bypass bit shifts
    run(op_ir, 3, 3'h4, 3'h1, 3'h7);
    mode(3'h4);
    v = rnd();
    run(op_dr, 8, v, {v[6:0], 1'b0}, 8'hff);
    chk(bsr_out, w, "clamp kept pins");
    // external test then exit, with and without the processor reset answer
    rs0 = rs_cnt;
    run(op_ir, 3, 3'h0, 3'h1, 3'h7);
    mode(3'h0);
    run(op_ir, 3, 3'h7, 3'h1, 3'h7);
    repeat (30) @(posedge clk);
    chk(rs_cnt, rs0 + 1, "reset start after exit");
    rsi_n <= 1'b0;
    run(op_ir, 3, 3'h0, 3'h1, 3'h7);
    run(op_ir, 3, 3'h7, 3'h1, 3'h7);
    repeat (30) @(posedge clk);
    chk(rs_cnt, rs0 + 1, "reset start cancelled");
    rsi_n <= 1'b1;
    // test-logic-reset clears the control cells
    run(op_reset, 1, '0, '0, '0);
    chk(bsr_out & CTL, '0, "control cells cleared");
    chk(active_instr, 3'h7, "instruction after reset");
    // power-on detect holds the controller; tdo floats to the pull level
    run(op_ir, 3, 3'h2, 3'h1, 3'h7);
    por <= 1'b1;
    repeat (10) @(posedge clk);
    chk(active_instr, 3'h7, "power-on forces reset");
    run(op_ir, 3, 3'h2, 3'h7, 3'h7);
    chk(active_instr, 3'h7, "command ignored");
    por <= 1'b0;
    run(op_reset, 1, '0, '0, '0);
    run(op_ir, 3, 3'h1, 3'h1, 3'h7);
    mode(3'h1);
    final_report();
  end
endmodule
